// ==== cdg_monitor.sv ====
// Port checker for the clock-domain controller.
// Assumes it is bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module cdg_monitor #(
  parameter int unsigned LOCK_CYC = 20
)
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_main_supply_good,
  input wire logic i_standby_supply_good,
  input wire logic i_core_supply_good,
  input wire logic i_host_reset_n,
  input wire logic i_host_clk_in,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic [7:0] o_clock_config_reg,
  input wire logic o_main_reset,
  input wire logic o_host_domain_clk,
  input wire logic o_fast_domain_clk,
  input wire logic o_gen_clock_valid,
  input wire logic o_slow_domain_clk,
  input wire logic o_slow_clock_valid
);
  localparam int LOCK_M1 = LOCK_CYC - 1;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_lock;
    !o_gen_clock_valid ##LOCK_M1 !o_gen_clock_valid ##1 o_gen_clock_valid;
  endsequence
  cfg_write_a: assert property (i_cfg_wr && !o_main_reset && i_host_reset_n && i_main_supply_good
    |=> o_clock_config_reg[0] == $past(i_cfg_wdata[0])) else $error("enable write lost");
  lock_time_a: assert property ($rose(o_clock_config_reg[0]) |-> s_lock)
    else $error("lock time wrong");
  fast_frozen_a: assert property (!o_gen_clock_valid |-> !o_fast_domain_clk)
    else $error("fast clock not frozen");
  valid_bit_a: assert property (o_clock_config_reg[1] == o_gen_clock_valid)
    else $error("valid bit mismatch");
  main_reset_a: assert property (!$past(i_srst) |->
    o_main_reset == (!$past(i_main_supply_good) || !$past(i_host_reset_n))) else $error("main reset wrong");
  host_clk_a: assert property (!$past(i_srst) && $past(i_main_supply_good) |->
    o_host_domain_clk == $past(i_host_clk_in)) else $error("host clock not passed");
  slow_gate_a: assert property (!o_slow_clock_valid [*3] |-> !o_slow_domain_clk)
    else $error("slow clock not held");
  slow_power_a: assert property (!(i_standby_supply_good && i_core_supply_good) |->
    ##[1:3] !o_slow_clock_valid) else $error("slow valid kept");
endmodule : cdg_monitor
bind clock_domain_generator_ctrl cdg_monitor #(.LOCK_CYC(LOCK_CYC)) i_mon (.*);
`default_nettype wire

// ==== clk_domain_pkg.sv ====
// Constants and types for the clock-domain controller.
// Assumes one 200 MHz reference clock and a synchronous active-high reset.
//
// Notes on behaviour
// - Standby slow domain comes from slow clock input.
// - Host and fast domains only with main supply.
// - Enable bit set starts the generator.
// - Generator output held low until stable.
// - Valid bit zero while locking, one after.
// - Output is reference times a fixed factor.
// - Slow domain active with standby and core supply.
// - Clock filter holds slow domain low until valid.
// - Slow domain toggles after wake plus validation delay.
// - Power-up reset holds until host reset released.
// - Host domain clocks bus interface and configuration; the code clocks the configuration register from i_ref_clk instead.
package clk_domain_pkg;
  // Clock period of the block, in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Generator lock delay, in microseconds
  localparam int unsigned GEN_LOCK_DELAY_US = 100;
  localparam int unsigned GEN_LOCK_CYC = (GEN_LOCK_DELAY_US * 1000000) / CLK_PERIOD_PS;
  // Slow-clock wake plus validation delay, in microseconds
  localparam int unsigned SLOW_WAKE_DELAY_US = 1000;
  localparam int unsigned SLOW_WAKE_CYC = (SLOW_WAKE_DELAY_US * 1000000) / CLK_PERIOD_PS;
  // Slow clock edges the filter must see in a row
  localparam int unsigned SLOW_EDGES_NEEDED = 4;
  // Window in which a slow clock edge must arrive (about two slow periods)
  localparam int unsigned SLOW_EDGE_WIN_CYC = 12500;
  // Fixed multiply factor of the generator, as a rational step
  localparam int unsigned GEN_MUL_NUM = 48000000;
  localparam int unsigned GEN_MUL_DEN = 14318180;
  // Clock configuration register layout
  localparam int unsigned CFG_ENABLE_BIT = 0;
  localparam int unsigned CFG_VALID_BIT = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic GEN_ENABLE_RESET = 1'b0;

  typedef enum logic [1:0] {
    GEN_OFF = 2'b00,
    GEN_LOCKING = 2'b01,
    GEN_RUN = 2'b10
  } gen_state_e;
endpackage : clk_domain_pkg

// ==== clk_src_model.sv ====
// Model of the host, reference and slow clock sources.
// Assumes the bench clock as time base; stopped clocks stand low.
`timescale 1ns/1ps
`default_nettype none
module clk_src_model (
  input wire logic i_ref_clk,
  input wire logic i_ref_run,
  input wire logic i_slow_run,
  output logic o_host_clk,
  output logic o_ref_clock,
  output logic o_slow_clock
);
  logic [7:0] cnt_r = 8'h00;
  always_ff @(posedge i_ref_clk)
    cnt_r <= cnt_r + 8'h01;
  assign o_host_clk = cnt_r[1];
  assign o_ref_clock = i_ref_run & cnt_r[2];
  assign o_slow_clock = i_slow_run & cnt_r[5];
endmodule : clk_src_model
`default_nettype wire

// ==== clock_domain_generator_ctrl.sv ====
// Clock-domain controller: host, fast generator and standby slow domains.
// Assumes supplies arrive as synchronous power-good levels and the
// reference and slow clocks as sampled levels.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Parameters and ports
module clock_domain_generator_ctrl
  import clk_domain_pkg::*;
#(
  parameter int unsigned LOCK_CYC = GEN_LOCK_CYC,
  parameter int unsigned SLOW_CYC = SLOW_WAKE_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_main_supply_good,
  input wire logic i_standby_supply_good,
  input wire logic i_core_supply_good,
  input wire logic i_host_reset_n,
  input wire logic i_host_clk_in,
  input wire logic i_ref_clock_in,
  input wire logic i_slow_clock_in,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_clock_config_reg,
  output logic o_main_reset,
  output logic o_host_domain_clk,
  output logic o_fast_domain_clk,
  output logic o_gen_clock_valid,
  output logic o_slow_domain_clk,
  output logic o_slow_clock_valid
);
  // ==========================================================================
  // State
  typedef struct packed {
    gen_state_e st;
    logic gen_enable_bit;
    logic [31:0] lock_cnt;
    logic [31:0] phase;
    logic ref_last;
    logic fast;
    logic valid;
    logic main_rst;
    logic host_clk;
    logic slow_clk;
    logic slow_valid;
    logic [7:0] cfg;
  } ctrl_s;
  ctrl_s q_r;
  ctrl_s q_nxt;

  // ==========================================================================
  // Slow filter
  slow_filter_if sf ();

  assign sf.slow_clock_in = i_slow_clock_in;
  assign sf.slow_power_good = i_standby_supply_good & i_core_supply_good;

  slow_clock_filter #(
    .WAKE_CYC(SLOW_CYC)
  ) u_filter (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .sf(sf)
  );

  // ==========================================================================
  // Functions
  // Rational phase step for the fixed multiply; the phase stays below the
  // divisor, and wrap is the parity of the output half-periods crossed
  function automatic logic [31:0] phase_step(input logic [31:0] ph, output logic wrap);
    logic [32:0] sum;
    sum = {1'b0, ph} + 33'(GEN_MUL_NUM);
    wrap = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (sum >= 33'(GEN_MUL_DEN))
      begin
        sum = sum - 33'(GEN_MUL_DEN);
        wrap = ~wrap;
      end
    end
    return sum[31:0];
  endfunction : phase_step

  // Main domain may run: supply on and power-up reset over
  function automatic logic main_live(input logic supply_good, input logic rst);
    return supply_good & ~rst;
  endfunction : main_live

  // Image of the clock configuration register
  function automatic logic [7:0] cfg_image(input logic en, input logic vld);
    logic [7:0] img;
    img = CFG_RESET;
    img[CFG_ENABLE_BIT] = en;
    img[CFG_VALID_BIT] = vld;
    return img;
  endfunction : cfg_image

  // Lock delay reached at the end of this cycle
  function automatic logic lock_reached(input logic [31:0] cnt);
    return (cnt + 32'd1) >= LOCK_CYC;
  endfunction : lock_reached

  // Rising edge of a sampled clock level
  function automatic logic ref_rise(input logic cur, input logic last);
    return cur & ~last;
  endfunction : ref_rise

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic tick;
    logic ref_edge;
    tick = 1'b0;
    q_nxt = q_r;
    ref_edge = ref_rise(i_ref_clock_in, q_r.ref_last);
    q_nxt.ref_last = i_ref_clock_in;
    // ========================================================================
    // Main domain gating
    // main reset until host reset released
    q_nxt.main_rst = ~i_main_supply_good | ~i_host_reset_n;
    q_nxt.host_clk = i_main_supply_good & i_host_clk_in;
    // ========================================================================
    // Configuration write
    // software write of enable
    if (i_cfg_wr && main_live(i_main_supply_good, q_r.main_rst))
      q_nxt.gen_enable_bit = i_cfg_wdata[CFG_ENABLE_BIT];
    // ========================================================================
    // Generator
    case (q_r.st)
      GEN_OFF:
      begin
        q_nxt.fast = 1'b0;
        q_nxt.valid = 1'b0;
        q_nxt.lock_cnt = '0;
        q_nxt.phase = '0;
        if (q_nxt.gen_enable_bit)
          q_nxt.st = GEN_LOCKING;
      end
      GEN_LOCKING:
      begin
        q_nxt.fast = 1'b0;
        // valid stays zero until lock delay
        q_nxt.valid = 1'b0;
        q_nxt.lock_cnt = q_r.lock_cnt + 32'd1;
        if (lock_reached(q_r.lock_cnt))
        begin
          q_nxt.st = GEN_RUN;
          q_nxt.valid = 1'b1;
        end
      end
      GEN_RUN:
      begin
        q_nxt.valid = 1'b1;
        if (ref_edge)
        begin
          q_nxt.phase = phase_step(q_r.phase, tick);
          if (tick)
            q_nxt.fast = ~q_r.fast;
        end
      end
      default:
        q_nxt.st = GEN_OFF;
    endcase
    // disable freezes the output at once
    if (!q_nxt.gen_enable_bit)
    begin
      q_nxt.st = GEN_OFF;
      q_nxt.fast = 1'b0;
      q_nxt.valid = 1'b0;
    end
    // ========================================================================
    // Power override
    // main supply off kills host and fast domains
    if (!main_live(i_main_supply_good, q_nxt.main_rst))
    begin
      q_nxt.gen_enable_bit = GEN_ENABLE_RESET;
      q_nxt.st = GEN_OFF;
      q_nxt.fast = 1'b0;
      q_nxt.valid = 1'b0;
    end
    // ========================================================================
    // Slow domain and status image
    q_nxt.slow_clk = sf.slow_domain_clk;
    q_nxt.slow_valid = sf.slow_clock_valid;
    q_nxt.cfg = cfg_image(q_nxt.gen_enable_bit, q_nxt.valid);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      q_r <= '0;
      q_r.st <= GEN_OFF;
      q_r.gen_enable_bit <= GEN_ENABLE_RESET;
      q_r.main_rst <= 1'b1;
      q_r.cfg <= CFG_RESET;
    end
    else
      q_r <= q_nxt;
  end

  // ==========================================================================
  // Outputs
  assign o_clock_config_reg = q_r.cfg;
  assign o_main_reset = q_r.main_rst;
  assign o_host_domain_clk = q_r.host_clk;
  assign o_fast_domain_clk = q_r.fast;
  assign o_gen_clock_valid = q_r.valid;
  assign o_slow_domain_clk = q_r.slow_clk;
  assign o_slow_clock_valid = q_r.slow_valid;
endmodule : clock_domain_generator_ctrl
`default_nettype wire

// ==== slow_clock_filter.sv ====
// Clock filter for the standby slow domain.
// Assumes the slow clock input is sampled as a synchronous level.
`timescale 1ns/1ps
`default_nettype none
module slow_clock_filter
  import clk_domain_pkg::*;
#(
  parameter int unsigned WAKE_CYC = SLOW_WAKE_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  slow_filter_if.filt sf
);
  typedef struct packed {
    logic [31:0] wake_cnt;
    logic [31:0] win_cnt;
    logic [3:0] edges;
    logic last_in;
    logic valid;
    logic dom;
  } filt_s;
  filt_s q_r;
  filt_s q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.last_in = sf.slow_clock_in;
    if (!sf.slow_power_good)
    begin
      q_nxt = '0;
      // Keep tracking the pin so power-up sees no false edge
      q_nxt.last_in = sf.slow_clock_in;
    end
    else
    begin
      if (q_r.wake_cnt < WAKE_CYC)
        q_nxt.wake_cnt = q_r.wake_cnt + 32'd1;
      if (sf.slow_clock_in != q_r.last_in)
      begin
        q_nxt.win_cnt = '0;
        if (q_r.edges < 4'(SLOW_EDGES_NEEDED))
          q_nxt.edges = q_r.edges + 4'd1;
      end
      else if (q_r.win_cnt >= SLOW_EDGE_WIN_CYC)
      begin
        // Input stopped: drop validity
        q_nxt.edges = '0;
      end
      else
        q_nxt.win_cnt = q_r.win_cnt + 32'd1;
      q_nxt.valid = (q_nxt.wake_cnt >= WAKE_CYC) && (q_nxt.edges >= 4'(SLOW_EDGES_NEEDED));
      q_nxt.dom = q_nxt.valid & sf.slow_clock_in;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign sf.slow_clock_valid = q_r.valid;
  assign sf.slow_domain_clk = q_r.dom;
endmodule : slow_clock_filter
`default_nettype wire

// ==== slow_filter_if.sv ====
// Carrier between the controller and its slow clock filter.
// Assumes one clock for both sides.
`timescale 1ns/1ps
`default_nettype none
interface slow_filter_if;
  logic slow_clock_in;
  logic slow_power_good;
  logic slow_clock_valid;
  logic slow_domain_clk;
  modport ctrl (output slow_clock_in, output slow_power_good, input slow_clock_valid, input slow_domain_clk);
  modport filt (input slow_clock_in, input slow_power_good, output slow_clock_valid, output slow_domain_clk);
endinterface : slow_filter_if
`default_nettype wire

// ==== tb_clock_domain_generator_ctrl.sv ====
// Testbench for the clock-domain controller.
// Assumes the clock-source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_clock_domain_generator_ctrl;
  import clk_domain_pkg::*;
  localparam int LOCK = 20;
  localparam int SLOW = 50;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_main_supply_good = 1'b1;
  logic i_standby_supply_good = 1'b0;
  logic i_core_supply_good = 1'b1;
  logic i_host_reset_n = 1'b1;
  logic i_cfg_wr = 1'b0;
  logic [7:0] i_cfg_wdata = 8'h00;
  logic ref_run = 1'b0;
  logic slow_run = 1'b1;
  logic i_host_clk_in, i_ref_clock_in, i_slow_clock_in;
  logic [7:0] o_clock_config_reg;
  logic o_main_reset, o_host_domain_clk, o_fast_domain_clk, o_gen_clock_valid, o_slow_domain_clk, o_slow_clock_valid;
  logic [4:0] flags;
  int n_errors = 0;
  int check_count = 0;
  int n;
  assign flags = {o_host_domain_clk, o_fast_domain_clk, o_slow_domain_clk, o_slow_clock_valid, o_gen_clock_valid};
  initial
  begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  clk_src_model i_src (.i_ref_clk(i_ref_clk), .i_ref_run(ref_run), .i_slow_run(slow_run),
    .o_host_clk(i_host_clk_in), .o_ref_clock(i_ref_clock_in), .o_slow_clock(i_slow_clock_in));
  clock_domain_generator_ctrl #(.LOCK_CYC(LOCK), .SLOW_CYC(SLOW)) i_dut (.*);
  task automatic step(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask : step
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d);
    i_cfg_wr = 1'b1;
    i_cfg_wdata = d;
    step(1);
    i_cfg_wr = 1'b0;
  endtask : wr
  task automatic wait_for(input int b, input logic v, input int lim);
    n = 0;
    while (flags[b] !== v)
    begin
      step(1);
      n++;
      if (n > lim)
      begin
        chk(flags[b], v);
        test_done();
      end
    end
  endtask : wait_for
  task automatic count_tog(input int b, input int cyc);
    logic p;
    n = 0;
    repeat (cyc)
    begin
      p = flags[b];
      step(1);
      if (flags[b] !== p)
        n++;
    end
  endtask : count_tog
  task automatic t_reset();
    chk(o_clock_config_reg, CFG_RESET);
    chk(o_main_reset, 1'b0);
    i_host_reset_n = 1'b0;
    step(1);
    wr(8'h01);
    step(1);
    chk({o_main_reset, o_clock_config_reg}, 9'h100);
    i_host_reset_n = 1'b1;
    step(2);
    chk(o_main_reset, 1'b0);
  endtask : t_reset
  task automatic t_gen();
    ref_run = 1'b1;
    step(40);
    wr(8'h01);
    chk({o_clock_config_reg, o_fast_domain_clk}, 9'h002);
    wait_for(0, 1'b1, LOCK + 4);
    chk(n, LOCK);
    chk(o_clock_config_reg, 8'h03);
    count_tog(3, 80);
    chk(n > 0, 1'b1);
    ref_run = 1'b0;
    step(4);
    count_tog(3, 40);
    chk(n, 0);
    ref_run = 1'b1;
  endtask : t_gen
  task automatic t_off();
    wr(8'h00);
    step(1);
    chk({o_clock_config_reg, o_gen_clock_valid, o_fast_domain_clk}, 10'h000);
    wr(8'h01);
    wait_for(0, 1'b1, LOCK + 4);
    count_tog(4, 16);
    chk(n > 0, 1'b1);
    i_main_supply_good = 1'b0;
    step(4);
    chk({o_main_reset, o_clock_config_reg, o_gen_clock_valid, o_fast_domain_clk}, 11'h400);
    count_tog(4, 16);
    chk(n, 0);
    i_main_supply_good = 1'b1;
    step(4);
    chk(o_clock_config_reg, 8'h00);
  endtask : t_off
  task automatic t_slow();
    i_standby_supply_good = 1'b1;
    wait_for(1, 1'b1, SLOW + 400);
    chk(n >= SLOW, 1'b1);
    count_tog(2, 100);
    chk(n > 0, 1'b1);
    i_core_supply_good = 1'b0;
    step(4);
    chk({o_slow_clock_valid, o_slow_domain_clk}, 2'b00);
    i_core_supply_good = 1'b1;
    wait_for(1, 1'b1, SLOW + 400);
    slow_run = 1'b0;
    wait_for(1, 1'b0, SLOW_EDGE_WIN_CYC + 100);
    chk(o_slow_domain_clk, 1'b0);
  endtask : t_slow
  initial
  begin
    step(16);
    i_srst = 1'b0;
    step(2);
    t_reset();
    t_gen();
    t_off();
    t_slow();
    test_done();
  end
endmodule : tb_clock_domain_generator_ctrl
`default_nettype wire
